/* olp_pkg.sv */
// Purpose: Shared constants and types for the output linearizer and carrier
// Assumes: 100 MHz clock, register index times four is the byte address
// Notes: Register indices follow the configuration word numbering
`default_nettype none
package olp_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    // Slowest carrier, 0.125 kHz, written in Hz
    localparam int unsigned BASE_FREQ_HZ = 125;
    localparam int unsigned BASE_PERIOD_CYC = CLK_HZ / BASE_FREQ_HZ;
    localparam int unsigned CNT_W = 20;

    localparam logic [5:0] IDX_CARRIER = 6'h07;
    localparam logic [5:0] IDX_COEFF_FIRST = 6'h0b;
    localparam logic [5:0] IDX_COEFF_LAST = 6'h1b;
    localparam logic [5:0] IDX_STATUS = 6'h20;
    localparam int unsigned COEFF_WORDS = 17;
    localparam int unsigned WORD_W = 24;

    localparam int unsigned TABLE_VALID_BIT = 23;
    localparam int unsigned POST_INV_BIT = 22;
    localparam int unsigned PRE_INV_BIT = 21;
    localparam int unsigned COEFF_HI_LSB = 12;
    localparam int unsigned COEFF_W = 12;
    localparam int unsigned STATUS_TABLE_BIT = 16;

    localparam logic [5:0] LAST_BREAKPOINT = 6'h20;
    localparam int unsigned FRAC_W = 7;
    localparam logic signed [13:0] MID_SCALE = 14'sh0800;
    localparam logic [11:0] FULL_CODE = 12'hfff;
    localparam logic [2:0] CARRIER_RESET = 3'h0;

    localparam logic [2:0] SEL_HALF = 3'h1;
    localparam logic [2:0] SEL_QUARTER = 3'h2;
    localparam logic [2:0] SEL_1K = 3'h3;
    localparam logic [2:0] SEL_2K = 3'h4;
    localparam logic [2:0] SEL_4K = 3'h5;

    // Period divide shift of the base carrier for each select code
    function automatic logic [2:0] carrier_shift(input logic [2:0] sel);
        logic [2:0] r;
        r = 3'h0;
        if (sel >= SEL_HALF && sel <= SEL_4K)
        begin
            r = sel;
        end
        return r;
    endfunction

    // Output resolution in bits for each select code
    function automatic logic [3:0] carrier_res(input logic [2:0] sel);
        logic [3:0] r;
        r = 4'hc;
        if (sel == SEL_1K)
        begin
            r = 4'hb;
        end
        else if (sel == SEL_2K)
        begin
            r = 4'ha;
        end
        else if (sel == SEL_4K)
        begin
            r = 4'h9;
        end
        return r;
    endfunction

    typedef struct packed {
        logic [2:0] carrier;
        logic [COEFF_WORDS-1:0][WORD_W-1:0] coeff_words;
        logic wr_pend;
        logic [5:0] wr_idx;
        logic [31:0] rdata;
        logic s1_valid;
        logic [11:0] s1_x;
        logic s1_table;
        logic s1_post;
        logic out_valid;
        logic [11:0] out_code;
        logic out_table;
    } olp_state_t;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] period;
        logic [CNT_W-1:0] duty;
        logic [3:0] res;
        logic [2:0] sel;
        logic pwm;
        logic pstart;
    } olp_pwm_state_t;

    localparam olp_state_t STATE_RESET = '0;
    localparam olp_pwm_state_t PWM_RESET = '0;
endpackage
`default_nettype wire

/* olp_pwm_carrier.sv */
// Purpose: Pulse-width carrier at a selectable frequency and resolution
// Assumes: Level is a 12-bit code from logic on the same clock
// Notes: A new select or level takes effect at the next period start
`default_nettype none
module olp_pwm_carrier #(
    parameter int unsigned BASE_PERIOD = olp_pkg::BASE_PERIOD_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [2:0] carrier_sel,
    input wire logic [11:0] level,
    output logic pwm_out,
    output logic period_start
);
    olp_pkg::olp_pwm_state_t st;
    olp_pkg::olp_pwm_state_t next_st;
    logic wrap;
    logic [olp_pkg::CNT_W-1:0] new_period;
    logic [3:0] new_res;
    logic [11:0] q;
    logic [31:0] prod;

    assign wrap = ({1'b0, st.cnt} + 21'h1) >= {1'b0, st.period};
    assign new_period = olp_pkg::CNT_W'(BASE_PERIOD >>
        olp_pkg::carrier_shift(carrier_sel)); // [R1] [R2] [R3]
    assign new_res = olp_pkg::carrier_res(carrier_sel); // [R2] [R3]
    // Level truncated to the resolution of the chosen carrier
    assign q = level >> (4'hc - new_res); // [R3]
    assign prod = 32'(q) * 32'(new_period);

    always_comb
    begin
        next_st = st;
        next_st.pstart = wrap;
        if (wrap)
        begin
            next_st.cnt = '0;
            next_st.period = new_period;
            next_st.res = new_res;
            next_st.sel = carrier_sel;
            next_st.duty = olp_pkg::CNT_W'(prod >> new_res);
        end
        else
        begin
            next_st.cnt = st.cnt + 1'b1;
        end
        next_st.pwm = next_st.cnt < next_st.duty;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st <= olp_pkg::PWM_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign pwm_out = st.pwm;
    assign period_start = st.pstart;

    a_slow_carrier: assert property ( // [R1]
        @(posedge clk) disable iff (sys_rst)
        st.pstart && (st.sel == 3'h0 || st.sel == 3'h6 || st.sel == 3'h7)
        |-> st.period == BASE_PERIOD && st.res == 4'hc)
        else $error("slow carrier period or resolution wrong");

    a_mid_carrier: assert property ( // [R2]
        @(posedge clk) disable iff (sys_rst)
        st.pstart && (st.sel == 3'h1 || st.sel == 3'h2)
        |-> st.period == (BASE_PERIOD >> st.sel) && st.res == 4'hc)
        else $error("0.25 or 0.5 kHz carrier wrong");

    a_fast_carrier: assert property ( // [R3]
        @(posedge clk) disable iff (sys_rst)
        st.pstart && st.sel >= 3'h3 && st.sel <= 3'h5
        |-> st.period == (BASE_PERIOD >> st.sel)
        && st.res == 4'(4'he - st.sel))
        else $error("fast carrier period or resolution wrong");
endmodule
`default_nettype wire

/* olp_linearizer.sv */
// Purpose: Output linearizer with polarity control, carrier and bus slave
// Assumes: AHB-Lite single word transfers, sample input on the same clock
// Notes: Zero wait states; coefficient table is a 32-segment lookup
//
// Overview of operation
// R1: Carrier select codes 000, 110 and 111 give a 0.125 kHz carrier.
// R2: Codes 001 and 010 give 0.25 and 0.5 kHz, all these at 12 bits.
// R3: Codes 011, 100 and 101 give 1, 2 and 4 kHz at 11, 10 and 9 bits.
// R4: The pre-table invert bit mirrors the signal before the table.
// R5: Pre-table inversion acts only while the table-valid flag is set.
// R6: The post-table invert bit mirrors the output, table or no table.
// R7: Every coefficient is a 12-bit two's complement number.
// R8: The programmer loads coefficients that rise with their index.
// R9: Without the table-valid flag the table is bypassed entirely.
// R10: Even coefficients sit low in words 0x0B-0x1B, odd ones high.
// R11: Coefficient x belongs to breakpoint x at (32-x)/32 of full scale.
// R12: The table works on the compensated, offset-corrected sample.
// R13: The table-valid flag is bit 23 of configuration word 0x1B.
// R14: Between breakpoints the output interpolates linearly.
// R15: Inversion mirrors the 12-bit code about mid-scale.
`default_nettype none
module olp_linearizer #(
    parameter int unsigned BASE_PERIOD = olp_pkg::BASE_PERIOD_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [11:0] comp_sample,
    input wire logic comp_valid,
    output logic [11:0] lin_code,
    output logic lin_valid,
    output logic pwm_out,
    output logic period_start
);
    olp_pkg::olp_state_t st;
    olp_pkg::olp_state_t next_st;
    logic bus_take;
    logic [5:0] bus_idx;
    logic table_on;
    logic pre_inv;
    logic post_inv;
    logic [4:0] seg;
    logic [olp_pkg::FRAC_W-1:0] frac;
    logic [5:0] lo_idx;
    logic [5:0] hi_idx;
    logic signed [11:0] c_lo;
    logic signed [11:0] c_hi;
    logic signed [12:0] diff;
    logic signed [20:0] prod;
    logic signed [13:0] interp;
    logic [11:0] table_code;
    logic [11:0] stage_code;

    // Coefficient i: word i/2, low half when even, high half when odd
    function automatic logic [11:0] coeff_at(
        input logic [olp_pkg::COEFF_WORDS-1:0][olp_pkg::WORD_W-1:0] w,
        input logic [5:0] i
    );
        logic [olp_pkg::WORD_W-1:0] wd;
        wd = w[i[5:1]];
        if (i[0])
        begin
            return wd[olp_pkg::COEFF_HI_LSB +: olp_pkg::COEFF_W]; // [R10]
        end
        return wd[olp_pkg::COEFF_W-1:0]; // [R10]
    endfunction

    function automatic logic [31:0] reg_read(
        input olp_pkg::olp_state_t s,
        input logic [5:0] idx
    );
        logic [31:0] r;
        r = 32'h0;
        if (idx == olp_pkg::IDX_CARRIER)
        begin
            r = {29'h0, s.carrier};
        end
        else if (idx >= olp_pkg::IDX_COEFF_FIRST &&
            idx <= olp_pkg::IDX_COEFF_LAST)
        begin
            r = {8'h0, s.coeff_words[5'(idx - olp_pkg::IDX_COEFF_FIRST)]};
        end
        else if (idx == olp_pkg::IDX_STATUS)
        begin
            r = {20'h0, s.out_code};
            r[olp_pkg::STATUS_TABLE_BIT] = s.out_table;
        end
        return r;
    endfunction

    // Address phase is taken whenever a selected NONSEQ or SEQ transfer meets hready
    assign bus_take = hsel && htrans[1] && hready;
    assign bus_idx = haddr[7:2];

    // Flags live in the last configuration word
    assign table_on = // [R13]
        st.coeff_words[olp_pkg::COEFF_WORDS-1][olp_pkg::TABLE_VALID_BIT];
    assign pre_inv =
        st.coeff_words[olp_pkg::COEFF_WORDS-1][olp_pkg::PRE_INV_BIT];
    assign post_inv =
        st.coeff_words[olp_pkg::COEFF_WORDS-1][olp_pkg::POST_INV_BIT];

    // Segment 0 is the bottom of the range, next to breakpoint 32
    assign seg = st.s1_x[11:7];
    assign frac = st.s1_x[olp_pkg::FRAC_W-1:0];
    assign lo_idx = olp_pkg::LAST_BREAKPOINT - {1'b0, seg}; // [R11]
    assign hi_idx = lo_idx - 6'h1; // [R11]
    assign c_lo = $signed(coeff_at(st.coeff_words, lo_idx)); // [R7]
    assign c_hi = $signed(coeff_at(st.coeff_words, hi_idx)); // [R7]
    assign diff = $signed({c_hi[11], c_hi}) - $signed({c_lo[11], c_lo});
    assign prod = diff * $signed({1'b0, frac}); // [R14]
    assign interp = $signed({{2{c_lo[11]}}, c_lo}) + $signed(prod[20:7])
        + olp_pkg::MID_SCALE; // [R14]

    // Signed table result is moved to an unsigned code and clamped
    always_comb
    begin
        if (interp < 14'sh0)
        begin
            table_code = 12'h0;
        end
        else if (interp > $signed({2'b00, olp_pkg::FULL_CODE}))
        begin
            table_code = olp_pkg::FULL_CODE;
        end
        else
        begin
            table_code = interp[11:0];
        end
    end

    always_comb
    begin
        // Table bypassed unless the table-valid flag was set
        stage_code = st.s1_table ? table_code : st.s1_x; // [R9]
        if (st.s1_post)
        begin
            stage_code = olp_pkg::FULL_CODE - stage_code; // [R6] [R15]
        end
    end

    always_comb
    begin
        next_st = st;
        next_st.wr_pend = 1'b0;
        if (st.wr_pend)
        begin
            if (st.wr_idx == olp_pkg::IDX_CARRIER)
            begin
                next_st.carrier = hwdata[2:0]; // [R1]
            end
            else if (st.wr_idx >= olp_pkg::IDX_COEFF_FIRST &&
                st.wr_idx <= olp_pkg::IDX_COEFF_LAST)
            begin
                next_st.coeff_words[
                    5'(st.wr_idx - olp_pkg::IDX_COEFF_FIRST)] =
                    hwdata[olp_pkg::WORD_W-1:0]; // [R10]
            end
        end
        if (bus_take)
        begin
            next_st.wr_pend = hwrite;
            next_st.wr_idx = bus_idx;
            if (!hwrite)
            begin
                next_st.rdata = reg_read(st, bus_idx);
            end
        end
        // Stage one takes the compensated sample, pre-inverts if enabled and the table is valid
        next_st.s1_valid = comp_valid; // [R12]
        if (comp_valid)
        begin
            next_st.s1_table = table_on;
            next_st.s1_post = post_inv;
            next_st.s1_x = (table_on && pre_inv) ?
                olp_pkg::FULL_CODE - comp_sample : comp_sample; // [R4] [R5]
        end
        next_st.out_valid = st.s1_valid;
        if (st.s1_valid)
        begin
            next_st.out_code = stage_code;
            next_st.out_table = st.s1_table;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st <= olp_pkg::STATE_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st.rdata;
    assign lin_code = st.out_code;
    assign lin_valid = st.out_valid;

    olp_pwm_carrier #(
        .BASE_PERIOD(BASE_PERIOD)
    ) u_carrier (
        .clk(clk),
        .sys_rst(sys_rst),
        .carrier_sel(st.carrier), // [R1]
        .level(st.out_code),
        .pwm_out(pwm_out),
        .period_start(period_start)
    );

    sequence s_sample_in;
        comp_valid;
    endsequence

    sequence s_code_out;
        ##2 lin_valid;
    endsequence

    a_pipe_latency: assert property ( // [R12]
        @(posedge clk) disable iff (sys_rst)
        s_sample_in |-> s_code_out)
        else $error("linearized code not two cycles after sample");

    a_pre_invert: assert property ( // [R4]
        @(posedge clk) disable iff (sys_rst)
        comp_valid && table_on && pre_inv
        |=> st.s1_x == olp_pkg::FULL_CODE - $past(comp_sample))
        else $error("pre-table inversion missing");

    a_pre_ignored: assert property ( // [R5]
        @(posedge clk) disable iff (sys_rst)
        comp_valid && !table_on |=> st.s1_x == $past(comp_sample))
        else $error("pre-table inversion applied without table");

    a_bypass_plain: assert property ( // [R9]
        @(posedge clk) disable iff (sys_rst)
        comp_valid && !table_on && !post_inv
        ##1 st.s1_valid |=> lin_code == $past(comp_sample, 2))
        else $error("table not bypassed");

    a_post_invert: assert property ( // [R6]
        @(posedge clk) disable iff (sys_rst)
        st.s1_valid && st.s1_post && !st.s1_table
        |=> lin_code == olp_pkg::FULL_CODE - $past(st.s1_x))
        else $error("post-table inversion missing");

    a_breakpoint_hit: assert property ( // [R11]
        @(posedge clk) disable iff (sys_rst)
        st.s1_valid && st.s1_table && !st.s1_post && frac == '0
        && !c_lo[11] |=> lin_code == $past(c_lo) + 12'h800)
        else $error("breakpoint coefficient not reproduced");

    a_carrier_write: assert property ( // [R1]
        @(posedge clk) disable iff (sys_rst)
        st.wr_pend && st.wr_idx == olp_pkg::IDX_CARRIER
        |=> st.carrier == $past(hwdata[2:0]))
        else $error("carrier select not written");

    a_flag_source: assert property ( // [R13]
        @(posedge clk) disable iff (sys_rst)
        comp_valid |=> st.s1_table
        == $past(st.coeff_words[olp_pkg::COEFF_WORDS-1][23]))
        else $error("table-valid flag not taken from bit 23");

    // Register reads and writes: read data stands in the cycle after the taken address
    sequence s_carrier_read;
        bus_take && !hwrite && bus_idx == olp_pkg::IDX_CARRIER;
    endsequence

    sequence s_status_read;
        bus_take && !hwrite && bus_idx == olp_pkg::IDX_STATUS;
    endsequence

    sequence s_flag_word_write;
        st.wr_pend && st.wr_idx == olp_pkg::IDX_COEFF_LAST;
    endsequence

    a_carrier_read: assert property ( // [R1]
        @(posedge clk) disable iff (sys_rst)
        s_carrier_read |=> hrdata == {29'h0, $past(st.carrier)})
        else $error("carrier select read back wrong");

    a_status_read: assert property ( // [R9]
        @(posedge clk) disable iff (sys_rst)
        s_status_read |=> hrdata[11:0] == $past(st.out_code)
        && hrdata[olp_pkg::STATUS_TABLE_BIT] == $past(st.out_table))
        else $error("status read back wrong");

    a_flag_word_write: assert property ( // [R13]
        @(posedge clk) disable iff (sys_rst)
        s_flag_word_write |=> st.coeff_words[olp_pkg::COEFF_WORDS-1]
        == $past(hwdata[olp_pkg::WORD_W-1:0]))
        else $error("flag word not written");

    a_first_word_write: assert property ( // [R10]
        @(posedge clk) disable iff (sys_rst)
        st.wr_pend && st.wr_idx == olp_pkg::IDX_COEFF_FIRST
        |=> st.coeff_words[0] == $past(hwdata[olp_pkg::WORD_W-1:0]))
        else $error("first coefficient word not written");

    a_unmapped_write: assert property ( // [R10]
        @(posedge clk) disable iff (sys_rst)
        st.wr_pend && st.wr_idx > olp_pkg::IDX_COEFF_LAST
        |=> $stable(st.coeff_words) && $stable(st.carrier))
        else $error("write outside the map changed a register");

    a_negative_coeff: assert property ( // [R7]
        @(posedge clk) disable iff (sys_rst)
        st.s1_valid && st.s1_table && !st.s1_post && frac == '0
        && c_lo[11] |=> lin_code == $past(c_lo) + 12'h800)
        else $error("negative coefficient not taken as signed");

    a_bypass_flag: assert property ( // [R9]
        @(posedge clk) disable iff (sys_rst)
        comp_valid && !table_on |=> !st.s1_table)
        else $error("table used without table-valid flag");

    a_table_flag_out: assert property ( // [R9]
        @(posedge clk) disable iff (sys_rst)
        st.s1_valid |=> st.out_table == $past(st.s1_table))
        else $error("table-used status not carried to output");

    a_no_stray_valid: assert property ( // [R12]
        @(posedge clk) disable iff (sys_rst)
        lin_valid |-> $past(comp_valid, 2))
        else $error("result strobe without a sample");

    a_code_holds: assert property ( // [R12]
        @(posedge clk) disable iff (sys_rst)
        !lin_valid |-> $stable(lin_code))
        else $error("result code moved without a strobe");

    a_post_table: assert property ( // [R6]
        @(posedge clk) disable iff (sys_rst)
        st.s1_valid && st.s1_post && st.s1_table
        |=> lin_code == olp_pkg::FULL_CODE - $past(table_code))
        else $error("post-table inversion missing after table");
endmodule
`default_nettype wire

/* olp_linearizer_tb_top.sv */
// Purpose: Self-checking bench for the output linearizer and carrier
// Assumes: Zero wait state AHB-Lite slave, carrier period shortened
// Notes: Coefficients form a rising ramp, so every index reads distinct
`default_nettype none
module olp_linearizer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BP = 1024;
    localparam int LIMIT = 60000;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    wire logic hready;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [11:0] comp_sample = 12'h0;
    logic comp_valid = 1'b0;
    logic [11:0] lin_code;
    logic lin_valid;
    logic pwm_out;
    logic period_start;
    int bad_count = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic [11:0] pts [5] = '{12'h000, 12'h800, 12'h0c0, 12'h700, 12'hf80};

    assign hready = hreadyout;

    olp_linearizer #(.BASE_PERIOD(BP)) olp_linearizer_i (
        .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .comp_sample(comp_sample),
        .comp_valid(comp_valid), .lin_code(lin_code),
        .lin_valid(lin_valid), .pwm_out(pwm_out),
        .period_start(period_start)
    );

    always #5 clk = ~clk;

    task automatic finish_test();
        $display("Checks %0d, errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            bad_count++;
            $display("ERROR at %0t: run did not finish in time", $time);
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what,
                got, exp);
        end
    endtask

    // One single-word transfer; read data lands in rd
    task automatic ahb(input logic wr, input logic [5:0] idx,
        input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0, "bus response");
    endtask

    task automatic rdchk(input logic [5:0] idx, input logic [31:0] exp);
        ahb(1'b0, idx, 32'h0);
        chk(rd, exp, "register read");
    endtask

    // Result shows in the cycle after the edge following the taken edge
    task automatic smp(input logic [11:0] c, input logic [11:0] exp);
        @(posedge clk);
        comp_sample <= c;
        comp_valid <= 1'b1;
        @(posedge clk);
        comp_valid <= 1'b0;
        @(posedge clk);
        #1;
        chk({31'h0, lin_valid}, 32'h1, "result strobe");
        chk({20'h0, lin_code}, {20'h0, exp}, "result code");
    endtask

    function automatic int ci(input int k);
        return -1024 + 64 * k;
    endfunction

    // Even fractions only, so the interpolation has no rounding
    function automatic logic [11:0] tab(input logic [11:0] c);
        int s;
        int a;
        int b;
        s = int'(c[11:7]);
        a = ci(32 - s);
        b = ci(31 - s);
        return 12'(a + (b - a) * int'(c[6:0]) / 128 + 2048);
    endfunction

    task automatic ctl(input logic tv, input logic post, input logic pre);
        ahb(1'b1, 6'h1b, {8'h00, tv, post, pre, 9'h000, 12'(ci(32))});
    endtask

    task automatic wait_start();
        do
        begin
            @(posedge clk);
            #1;
        end
        while (period_start !== 1'b1);
    endtask

    task automatic carrier(input logic [2:0] sel, input logic [11:0] code);
        int sh;
        int res;
        int per;
        int len;
        int hi;
        sh = (sel >= 3'h1 && sel <= 3'h5) ? int'(sel) : 0;
        res = (sel == 3'h3) ? 11 : (sel == 3'h4) ? 10 :
            (sel == 3'h5) ? 9 : 12;
        per = BP >> sh;
        ahb(1'b1, 6'h07, {29'h0, sel});
        wait_start();
        wait_start();
        len = 0;
        hi = 0;
        do
        begin
            hi += (pwm_out === 1'b1) ? 1 : 0;
            len++;
            @(posedge clk);
            #1;
        end
        while (period_start !== 1'b1);
        chk(32'(len), 32'(per), "carrier period");
        chk(32'(hi), 32'(((int'(code) >> (12 - res)) * per) >> res),
            "carrier duty");
    endtask

    initial
    begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        chk({20'h0, lin_code}, 32'h0, "reset code");
        rdchk(6'h07, 32'h0);
        rdchk(6'h1b, 32'h0);
        ahb(1'b1, 6'h3f, 32'hffff_ffff);
        rdchk(6'h3f, 32'h0);
        ahb(1'b1, 6'h07, 32'hffff_ffff);
        rdchk(6'h07, 32'h7);
        ahb(1'b1, 6'h0c, 32'hffff_ffff);
        rdchk(6'h0c, 32'h00ff_ffff);
        for (int j = 0; j < 16; j++)
        begin
            ahb(1'b1, 6'h0b + 6'(j), {8'h00, 12'(ci(2 * j + 1)),
                12'(ci(2 * j))});
        end
        ctl(1'b0, 1'b0, 1'b1);
        rdchk(6'h0b, {8'h00, 12'(ci(1)), 12'(ci(0))});
        rdchk(6'h13, {8'h00, 12'(ci(17)), 12'(ci(16))});
        smp(12'h123, 12'h123);
        ctl(1'b0, 1'b1, 1'b0);
        smp(12'h123, 12'hedc);
        ctl(1'b1, 1'b0, 1'b0);
        foreach (pts[i])
        begin
            smp(pts[i], tab(pts[i]));
        end
        rdchk(6'h20, {15'h0, 1'b1, 4'h0, tab(12'hf80)});
        ctl(1'b1, 1'b0, 1'b1);
        smp(12'hf7f, tab(12'h080));
        ctl(1'b1, 1'b1, 1'b1);
        smp(12'h0ff, 12'hfff - tab(12'hf00));
        ctl(1'b0, 1'b0, 1'b0);
        smp(12'h9a5, 12'h9a5);
        rdchk(6'h20, 32'h0000_09a5);
        for (int s = 0; s < 8; s++)
        begin
            carrier(3'(s), 12'h9a5);
        end
        finish_test();
    end
endmodule
`default_nettype wire
